// ===== hdl/pwr_seq_pkg.sv
package pwr_seq_pkg;
  // cpu control register bit positions
  localparam int unsigned MODE_HI_BIT = 6;
  localparam int unsigned MODE_LO_BIT = 3;
  localparam int unsigned BUS_EXIT_BIT = 5;
  // io control register bit position
  localparam int unsigned IO_STOP_BIT = 5;
  // register offsets on the control port
  localparam logic [7:0] CPU_CTRL_OFS = 8'h1f;
  localparam logic [7:0] IO_CTRL_OFS = 8'h3f;
  localparam logic [7:0] ITC_OFS = 8'h34;
  localparam logic [7:0] STATUS_OFS = 8'h40;
  // reset values
  localparam logic [7:0] CPU_CTRL_RST = 8'h00;
  localparam logic [7:0] IO_CTRL_RST = 8'h00;
  localparam logic [7:0] ITC_RST = 8'h01;
  // wake counter lengths in clocks, and counter width in bits
  localparam int unsigned STAB_LONG_CYC = 131072;
  localparam int unsigned STAB_QUICK_CYC = 64;
  localparam int unsigned IDLE_EXIT_CYC = 8;
  localparam int unsigned CNT_W = 18;

  typedef enum logic [1:0] {
    MODE_STOP,
    MODE_IDLE,
    MODE_STANDBY,
    MODE_QUICK
  } mode_type;

  typedef enum {
    ST_RUN,
    ST_SLEEP,
    ST_WAIT,
    ST_BUSREL
  } state_type;

  typedef struct packed {
    logic [19:0] addr;
    logic memory_request_strobe_n;
    logic io_request_strobe_n;
    logic rd_n;
    logic wr_n;
  } bus_out_type;

  typedef struct packed {
    logic nmi;
    logic irq0;
    logic irq1;
    logic irq2;
  } wake_src_type;
endpackage

// ===== hdl/standby_idle_power_control.sv
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module standby_idle_power_control
  import pwr_seq_pkg::*;
#(
  parameter int unsigned STAB_LONG = STAB_LONG_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // cpu core handshake
  input wire logic sleep_exec,
  input wire logic global_int_enable_flag,
  output logic wake_ack_nmi,
  output logic wake_ack_irq,
  output logic wake_resume,
  // wake sources, active high levels except nmi_n, which wakes on its falling edge
  input wire logic reset_wake,
  input wire logic nmi_n,
  input wire logic ext_irq_zero,
  input wire logic ext_irq_one,
  input wire logic ext_irq_two,
  input wire logic bus_request_in,
  // clock control
  output logic osc_enable,
  output logic core_clk_enable,
  output logic system_clock_out_enable,
  output logic cpu_stopped,
  // bus
  input wire bus_out_type bus_core,
  output bus_out_type bus_out,
  output logic bus_oe,
  output logic bus_grant_out
);

  logic [7:0] cpu_control_reg_ff;
  logic [7:0] io_control_reg_ff;
  logic [7:0] interrupt_trap_control_reg_ff;
  logic [7:0] rdata_ff;
  state_type state_ff, nxt_state;
  mode_type mode_ff, nxt_mode;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic nmi_d_ff;
  logic nmi_latch_ff;
  logic by_bus_ff, nxt_by_bus;
  logic ack_nmi_ff, ack_irq_ff, resume_ff;
  logic nxt_ack_nmi, nxt_ack_irq, nxt_resume;

  function automatic mode_type decode_mode(input logic [7:0] cpu_control_reg);
    unique case ({cpu_control_reg[MODE_HI_BIT], cpu_control_reg[MODE_LO_BIT]})
      2'b10: decode_mode = MODE_STANDBY;
      2'b01: decode_mode = MODE_IDLE;
      2'b11: decode_mode = MODE_QUICK;
      default: decode_mode = MODE_STOP;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] wait_len(input mode_type m, input int unsigned long_len);
    unique case (m)
      MODE_QUICK: wait_len = CNT_W'(STAB_QUICK_CYC - 1);
      MODE_IDLE: wait_len = CNT_W'(IDLE_EXIT_CYC - 1);
      default: wait_len = CNT_W'(long_len - 1);
    endcase
  endfunction

  // register access
  wire wr_cpu = reg_wr && (reg_addr == CPU_CTRL_OFS);
  wire wr_io = reg_wr && (reg_addr == IO_CTRL_OFS);
  wire wr_itc = reg_wr && (reg_addr == ITC_OFS);
  wire [7:0] status_val = {4'h0, nmi_latch_ff, by_bus_ff, 2'(mode_ff)};
  wire [7:0] rd_mux = (reg_addr == CPU_CTRL_OFS) ? cpu_control_reg_ff :
                      (reg_addr == IO_CTRL_OFS) ? io_control_reg_ff :
                      (reg_addr == ITC_OFS) ? interrupt_trap_control_reg_ff :
                      (reg_addr == STATUS_OFS) ? status_val : 8'h00;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cpu_control_reg_ff <= CPU_CTRL_RST;
      io_control_reg_ff <= IO_CTRL_RST;
      interrupt_trap_control_reg_ff <= ITC_RST;
      rdata_ff <= 8'h00;
    end else begin
      if (wr_cpu) cpu_control_reg_ff <= reg_wdata;
      if (wr_io) io_control_reg_ff <= reg_wdata;
      if (wr_itc) interrupt_trap_control_reg_ff <= reg_wdata;
      rdata_ff <= reg_rd ? rd_mux : 8'h00;
    end
  end
  assign reg_rdata = rdata_ff;

  // wake conditions
  wire bus_exit_en = cpu_control_reg_ff[BUS_EXIT_BIT];
  wire io_stop = io_control_reg_ff[IO_STOP_BIT];
  wire nmi_fall = nmi_d_ff && !nmi_n;
  wire [2:0] irq_en = interrupt_trap_control_reg_ff[2:0];
  wire [2:0] irq_lvl = {ext_irq_two, ext_irq_one, ext_irq_zero};
  wire irq_wake = |(irq_lvl & irq_en);
  wire bus_wake = bus_exit_en && bus_request_in;
  wire nmi_wake = nmi_fall || nmi_latch_ff;
  wire any_wake = reset_wake || nmi_wake || irq_wake || bus_wake;
  wire hold_ok = reset_wake || nmi_latch_ff || irq_wake || (by_bus_ff && bus_request_in);
  wire deep = (mode_ff != MODE_STOP);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      nmi_d_ff <= 1'b1;
      nmi_latch_ff <= 1'b0;
    end else begin
      nmi_d_ff <= nmi_n;
      if (nmi_fall && state_ff != ST_RUN) nmi_latch_ff <= 1'b1;
      else if (state_ff == ST_RUN) nmi_latch_ff <= 1'b0;
    end
  end

  // sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_mode = mode_ff;
    nxt_cnt = cnt_ff;
    nxt_by_bus = by_bus_ff;
    nxt_ack_nmi = 1'b0;
    nxt_ack_irq = 1'b0;
    nxt_resume = 1'b0;
    unique case (state_ff)
      ST_RUN: begin
        if (sleep_exec && io_stop) begin
          nxt_mode = decode_mode(cpu_control_reg_ff);
          nxt_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (any_wake) begin
          nxt_state = ST_WAIT;
          nxt_cnt = wait_len(mode_ff, STAB_LONG);
          nxt_by_bus = bus_wake && !(reset_wake || nmi_wake || irq_wake);
          if (!deep) begin
            nxt_cnt = '0;
          end
        end
      end
      ST_WAIT: begin
        if (!hold_ok && !(by_bus_ff && bus_request_in)) begin
          nxt_state = ST_SLEEP;
        end else if (cnt_ff == '0) begin
          if (by_bus_ff || bus_request_in) begin
            nxt_state = ST_BUSREL;
          end else begin
            nxt_state = ST_RUN;
          end
          nxt_ack_nmi = nmi_latch_ff;
          nxt_ack_irq = !nmi_latch_ff && !reset_wake && irq_wake && global_int_enable_flag;
          nxt_resume = !nmi_latch_ff && !reset_wake && irq_wake && !global_int_enable_flag;
        end else begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        end
      end
      ST_BUSREL: begin
        if (!bus_request_in) begin
          nxt_state = ST_RUN;
          nxt_by_bus = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_RUN;
      mode_ff <= MODE_STOP;
      cnt_ff <= '0;
      by_bus_ff <= 1'b0;
      ack_nmi_ff <= 1'b0;
      ack_irq_ff <= 1'b0;
      resume_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      mode_ff <= nxt_mode;
      cnt_ff <= nxt_cnt;
      by_bus_ff <= nxt_by_bus;
      ack_nmi_ff <= nxt_ack_nmi;
      ack_irq_ff <= nxt_ack_irq;
      resume_ff <= nxt_resume;
    end
  end

  // clock gating
  wire asleep = (state_ff == ST_SLEEP) || (state_ff == ST_WAIT);
  wire osc_off = (state_ff == ST_SLEEP) &&
                 (mode_ff == MODE_STANDBY || mode_ff == MODE_QUICK);
  assign osc_enable = !osc_off;
  assign core_clk_enable = !(asleep && deep);
  assign system_clock_out_enable = !(asleep && deep);
  assign cpu_stopped = asleep;
  assign wake_ack_nmi = ack_nmi_ff;
  assign wake_ack_irq = ack_irq_ff;
  assign wake_resume = resume_ff;

  // bus drive
  wire released = (state_ff == ST_BUSREL);
  assign bus_grant_out = released;
  assign bus_oe = !released;
  assign bus_out = asleep ? '1 : bus_core;

  // wait length watch for assertions
  logic [CNT_W:0] wait_run_ff;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wait_run_ff <= '0;
    end else if (state_ff == ST_WAIT) begin
      wait_run_ff <= wait_run_ff + (CNT_W+1)'(1);
    end else begin
      wait_run_ff <= '0;
    end
  end

  a_nmi_ack_after_wait: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    wake_ack_nmi |-> $past(nmi_latch_ff))
    else $error("nmi ack without latch");

  a_bus_float_grant: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    bus_grant_out |-> !bus_oe)
    else $error("grant with bus driven");

  a_release_on_drop: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (released && !bus_request_in) |=> !bus_grant_out)
    else $error("bus not reclaimed");

  a_osc_standby_off: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (state_ff == ST_SLEEP && mode_ff == MODE_STANDBY) |-> !osc_enable)
    else $error("osc running in standby");

  a_idle_osc_on: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (asleep && mode_ff == MODE_IDLE) |-> (osc_enable && !core_clk_enable))
    else $error("idle gating wrong");

  a_stop_clk_runs: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (mode_ff == MODE_STOP) |-> system_clock_out_enable)
    else $error("stop gated clock");

  a_quick_count_len: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (state_ff == ST_SLEEP && nxt_state == ST_WAIT && mode_ff == MODE_QUICK) |=> cnt_ff == 18'h0003f)
    else $error("quick count wrong");

  a_idle_exit_eight: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (state_ff == ST_SLEEP && nxt_state == ST_WAIT && mode_ff == MODE_IDLE) |=> cnt_ff == 18'h00007)
    else $error("idle count wrong");

  a_bus_disabled_ign: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (state_ff == ST_SLEEP && !bus_exit_en && !reset_wake && !nmi_wake && !irq_wake) |=> state_ff == ST_SLEEP)
    else $error("woke on ignored source");

  a_drop_restarts: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (state_ff == ST_WAIT && !hold_ok && !(by_bus_ff && bus_request_in)) |=> state_ff == ST_SLEEP)
    else $error("no restart on drop");

  a_long_count_len: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (state_ff == ST_SLEEP && nxt_state == ST_WAIT && mode_ff == MODE_STANDBY) |=> cnt_ff == CNT_W'(STAB_LONG - 1))
    else $error("standby count wrong");

  a_sleep_entry: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (state_ff == ST_RUN && sleep_exec && io_stop) |=> state_ff == ST_SLEEP)
    else $error("sleep not entered");

  a_mode_standby: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (state_ff == ST_RUN && sleep_exec && io_stop && cpu_control_reg_ff[6] && !cpu_control_reg_ff[3]) |=> mode_ff == MODE_STANDBY)
    else $error("standby not decoded");

  a_mode_idle: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (state_ff == ST_RUN && sleep_exec && io_stop && !cpu_control_reg_ff[6] && cpu_control_reg_ff[3]) |=> mode_ff == MODE_IDLE)
    else $error("idle not decoded");

  a_mode_quick: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (state_ff == ST_RUN && sleep_exec && io_stop && cpu_control_reg_ff[6] && cpu_control_reg_ff[3]) |=> mode_ff == MODE_QUICK)
    else $error("quick not decoded");

  a_stop_osc_runs: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (mode_ff == MODE_STOP) |-> osc_enable)
    else $error("stop halted oscillator");

  a_standby_clk_off: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (asleep && (mode_ff == MODE_STANDBY || mode_ff == MODE_QUICK)) |-> (!core_clk_enable && !system_clock_out_enable))
    else $error("clocks running in standby");

  a_wait_osc_on: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (state_ff == ST_WAIT) |-> osc_enable)
    else $error("oscillator off while counting");

  a_bus_wake_taken: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (state_ff == ST_SLEEP && bus_exit_en && bus_request_in) |=> state_ff == ST_WAIT)
    else $error("bus request did not wake");

  a_bus_kept_held: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (released && bus_request_in) |=> released)
    else $error("bus taken back during request");

  a_irq_masked_ign: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (state_ff == ST_SLEEP && (irq_lvl & irq_en) == 3'h0 && !reset_wake && !nmi_wake && !bus_wake) |=> state_ff == ST_SLEEP)
    else $error("masked irq woke");

  a_irq_ack_flag: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    wake_ack_irq |-> ($past(global_int_enable_flag) && $past(irq_wake)))
    else $error("irq ack without flag");

  a_irq_resume_flag: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    wake_resume |-> (!$past(global_int_enable_flag) && $past(irq_wake)))
    else $error("resume with flag set");

  a_irq_gone_stays: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (state_ff == ST_WAIT && !reset_wake && !nmi_latch_ff && !irq_wake && !by_bus_ff) |=> state_ff == ST_SLEEP)
    else $error("left standby without irq");

  a_nmi_latch_keeps: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (nmi_latch_ff && state_ff != ST_RUN) |=> nmi_latch_ff)
    else $error("nmi latch lost");

  a_wait_bounded: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    wait_run_ff <= (CNT_W+1)'(STAB_LONG))
    else $error("wake wait too long");

  a_acks_onehot: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    $onehot0({wake_ack_nmi, wake_ack_irq, wake_resume}))
    else $error("several wake pulses");

  c_bus_wake: cover property (@(posedge clk_sys) disable iff (!rstn) released);
  c_nmi_wake: cover property (@(posedge clk_sys) disable iff (!rstn) wake_ack_nmi);
  c_irq_resume: cover property (@(posedge clk_sys) disable iff (!rstn) wake_resume);
  c_restart: cover property (@(posedge clk_sys) disable iff (!rstn)
    state_ff == ST_WAIT ##1 state_ff == ST_SLEEP);
  c_idle_exit: cover property (@(posedge clk_sys) disable iff (!rstn)
    state_ff == ST_WAIT && mode_ff == MODE_IDLE && cnt_ff == '0);

endmodule
`default_nettype wire

// ===== tb/ext_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module ext_master_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // commands from the bench
  input wire logic want_bus,
  input wire logic [3:0] src_cmd,
  // pins toward the block
  input wire logic bus_grant_out,
  output logic bus_request_in,
  output logic nmi_n,
  output logic [2:0] irq
);
  logic [2:0] hold_ff;
  // sources held exactly as long as commanded
  assign nmi_n = ~src_cmd[3];
  assign irq = src_cmd[2:0];
  // request kept until five granted cycles, then released
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bus_request_in <= 1'b0;
      hold_ff <= 3'h0;
    end else begin
      bus_request_in <= want_bus && (hold_ff != 3'h5);
      if (!want_bus) begin
        hold_ff <= 3'h0;
      end else if (bus_grant_out && hold_ff != 3'h5) begin
        hold_ff <= hold_ff + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/standby_idle_power_control_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module standby_idle_power_control_tb_top;
  import pwr_seq_pkg::*;
  localparam int N = 100;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, sleep_exec = 1'b0, gflag = 1'b0, want_bus = 1'b0;
  logic ack_nmi, ack_irq, resume, nmi_n, breq, osc, core, clko, stopped, bus_oe, grant;
  logic [2:0] irq;
  logic [3:0] src_cmd = 4'h0;
  logic [15:0] r = 16'h6aa5, bs = 16'h6aa5;
  bus_out_type bus_core = '0;
  bus_out_type bus_out;
  int errors = 0, samples_checked = 0, cyc = 0, n;
  always #2.5 clk_sys = ~clk_sys;
  standby_idle_power_control #(.STAB_LONG(N)) u_standby_idle_power_control (
    .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_exec(sleep_exec),
    .global_int_enable_flag(gflag), .wake_ack_nmi(ack_nmi), .wake_ack_irq(ack_irq),
    .wake_resume(resume), .reset_wake(1'b0), .nmi_n(nmi_n), .ext_irq_zero(irq[0]),
    .ext_irq_one(irq[1]), .ext_irq_two(irq[2]), .bus_request_in(breq), .osc_enable(osc),
    .core_clk_enable(core), .system_clock_out_enable(clko), .cpu_stopped(stopped),
    .bus_core(bus_core), .bus_out(bus_out), .bus_oe(bus_oe), .bus_grant_out(grant));
  ext_master_model u_ext_master_model (.clk_sys(clk_sys), .rstn(rstn), .want_bus(want_bus),
    .src_cmd(src_cmd), .bus_grant_out(grant), .bus_request_in(breq), .nmi_n(nmi_n),
    .irq(irq));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int lat(input int m);
    return m == 0 ? 1 : m == 1 ? IDLE_EXIT_CYC : m == 2 ? N : STAB_QUICK_CYC;
  endfunction
  function automatic logic [2:0] clk_exp(input int m);
    return m == 0 ? 3'h7 : m == 1 ? 3'h4 : 3'h0;
  endfunction
  task automatic report_and_stop();
    if (errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick(1);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata);
    tick(1);
  endtask
  task automatic go_sleep(input logic [1:0] m, input logic bx);
    wr(CPU_CTRL_OFS, {1'b0, m[1], bx, 1'b0, m[0], 3'h0});
    wr(IO_CTRL_OFS, 8'h20);
    sleep_exec <= 1'b1;
    tick(1);
    sleep_exec <= 1'b0;
    rd_chk(STATUS_OFS, {6'h0, m});
    #1 chk("clocks asleep", clk_exp(m), {osc, core, clko});
    chk("bus asleep", 24'hffffff, bus_out);
  endtask
  task automatic wait_ack(input int lo, input int hi, input logic [2:0] e);
    n = 0;
    while (n <= hi) begin
      tick(1);
      #1 n++;
      if (ack_nmi | ack_irq | resume) break;
    end
    chk("wake pulses", e, {ack_nmi, ack_irq, resume});
    chk("wake latency", 1, n >= lo && n <= hi);
  endtask
  always @(posedge clk_sys) begin
    bs <= lfsr(bs);
    bus_core <= bus_out_type'({bs, bs[7:0]});
    cyc++;
    if (cyc == 6000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    tick(10);
    rstn <= 1'b1;
    tick(1);
    rd_chk(CPU_CTRL_OFS, CPU_CTRL_RST);
    rd_chk(IO_CTRL_OFS, IO_CTRL_RST);
    rd_chk(ITC_OFS, ITC_RST);
    rd_chk(8'h55, 8'h00);
    wr(ITC_OFS, 8'h07);
    // every mode, woken by a random enabled irq; quick mode assumes a fast oscillator
    for (int m = 0; m < 4; m++) begin
      r = lfsr(r);
      gflag <= r[0];
      go_sleep(2'(m), 1'b0);
      src_cmd <= 4'(1 << (r[2:1] % 3));
      wait_ack(lat(m), lat(m) + 6, {1'b0, r[0], ~r[0]});
      src_cmd <= 4'h0;
      tick(2);
      #1 chk("clocks awake", 4'he, {osc, core, clko, stopped});
    end
    // source dropped early, then an nmi pulse released before the count ends
    go_sleep(2'h2, 1'b0);
    src_cmd <= 4'h1;
    tick(20);
    src_cmd <= 4'h0;
    tick(4);
    #1 chk("early drop", 4'h1, {osc, core, clko, stopped});
    src_cmd <= 4'h8;
    tick(2);
    src_cmd <= 4'h0;
    wait_ack(N - 2, N + 6, 3'h4);
    // disabled irq and disabled bus exit never wake; enabled irq with request held
    wr(ITC_OFS, 8'h05);
    gflag <= 1'b1;
    go_sleep(2'h2, 1'b0);
    src_cmd <= 4'h2;
    want_bus <= 1'b1;
    tick(N + 20);
    #1 chk("no wake", 4'h1, {osc, core, clko, stopped});
    src_cmd <= 4'h6;
    wait_ack(N, N + 6, 3'h2);
    tick(1);
    #1 chk("bus kept released", 2'h2, {grant, bus_oe});
    src_cmd <= 4'h0;
    tick(10);
    #1 chk("bus reclaimed", 2'h1, {grant, bus_oe});
    want_bus <= 1'b0;
    tick(2);
    // bus request wake with exit enabled
    go_sleep(2'h2, 1'b1);
    want_bus <= 1'b1;
    n = 0;
    while (grant !== 1'b1 && n < N + 20) begin
      tick(1);
      #1 n++;
    end
    chk("bus wake latency", 1, n >= N && n <= N + 8);
    chk("bus released", 3'h6, {core, clko, bus_oe});
    tick(10);
    #1 chk("bus retaken", 3'h1, {grant, stopped, bus_oe});
    chk("bus driven", bus_core, bus_out);
    want_bus <= 1'b0;
    tick(2);
    report_and_stop();
  end
endmodule
`default_nettype wire
